// ---- bench/drmsr_chk.sv ----
// Port assertions for the reset, supply monitor and toggle register bank
`timescale 1ns/100ps
module drmsr_chk #(
	parameter int RESET_DELAY_CYC = 8
) (
	input wire logic mclk_in, // Clock
	input wire logic reset_n_in, // Reset, active low
	input wire logic analog_fail_in, // Analog failure
	input wire logic trigger_input_in, // Trigger level
	input wire logic frame_end_in, // Frame end pulse
	input wire logic wb_cyc_in, // Bus cycle
	input wire logic wb_stb_in, // Bus strobe
	input wire logic wb_we_in, // Bus write
	input wire logic [3:0] wb_adr_in, // Bus index
	input wire logic [31:0] wb_dat_out, // Read data
	input wire logic wb_ack_out, // Acknowledge
	input wire logic prepare_out, // Prepare pulse
	input wire logic output_toggle_out, // Output toggle pulse
	input wire logic dac_clear_out, // Clear state
	input wire logic [3:0] subsys_reset_out // Subsystem resets
);
	import drmsr_pkg::*;
	logic [11:0] hi_q;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	// Length of the current subsystem reset
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hi_q <= 12'h000;
		end else if (|subsys_reset_out) begin
			hi_q <= hi_q + 12'h001;
		end else begin
			hi_q <= 12'h000;
		end
	end
	AST_ACK_LAT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack not one cycle after request");
	AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	AST_VERSION: assert property (
		wb_ack_out && !wb_we_in && wb_adr_in == IDX_SOFT_RESET |-> wb_dat_out == {16'h0000, HW_VERSION})
		else $error("soft reset word read wrong");
	AST_UNMAPPED: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 4'h0 |-> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	AST_CLEAR: assert property (1'b1 |=> dac_clear_out == $past(analog_fail_in))
		else $error("clear state not following analog failure");
	AST_SWR_SRC: assert property (
		$rose(|subsys_reset_out) |-> $past(frame_end_in) || $past(frame_end_in, 2))
		else $error("subsystem reset without frame end");
	AST_SWR_LEN: assert property ($fell(|subsys_reset_out) |-> hi_q == 12'(RESET_DELAY_CYC + 1))
		else $error("subsystem reset length wrong");
	AST_PREPARE: assert property ($rose(trigger_input_in) |-> ##[1:3] prepare_out)
		else $error("no prepare after trigger rise");
	AST_OUT_TOG: assert property ($fell(trigger_input_in) |-> ##[1:3] output_toggle_out)
		else $error("no output toggle after trigger fall");
	cover property ($rose(|subsys_reset_out));
	cover property (prepare_out);
	cover property (output_toggle_out);
endmodule : drmsr_chk
bind drmsr_regs drmsr_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) drmsr_chk_i (
	.mclk_in(mclk_in), .reset_n_in(reset_n_in), .analog_fail_in(analog_fail_in),
	.trigger_input_in(trigger_input_in), .frame_end_in(frame_end_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .prepare_out(prepare_out), .output_toggle_out(output_toggle_out),
	.dac_clear_out(dac_clear_out), .subsys_reset_out(subsys_reset_out));

// ---- bench/drmsr_host_model.sv ----
// Host side model: frame ends and trigger pulses
`timescale 1ns/100ps
module drmsr_host_model #(
	parameter int DELAY = 8
) (
	input wire logic mclk_in, // Clock
	output logic frame_end_out, // Chip-select rising edge
	output logic [1:0] subsys_out, // Frame subsystem
	output logic trigger_out // Trigger level
);
	initial begin
		frame_end_out = 1'b0;
		subsys_out = 2'h3;
		trigger_out = 1'b0;
	end
	task automatic frame(input logic [1:0] sid);
		@(posedge mclk_in);
		frame_end_out <= 1'b1;
		subsys_out <= sid;
		@(posedge mclk_in);
		frame_end_out <= 1'b0;
		subsys_out <= ~sid;
	endtask : frame
	// Stay silent while a soft reset runs
	task automatic settle();
		repeat (DELAY + 3) @(posedge mclk_in);
	endtask : settle
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge mclk_in);
			trigger_out <= 1'b1;
			repeat (4) @(posedge mclk_in);
			trigger_out <= 1'b0;
			repeat (4) @(posedge mclk_in);
		end
	endtask : pulses
endmodule : drmsr_host_model

// ---- bench/drmsr_regs_bench.sv ----
// Self-checking bench for the reset, supply monitor and toggle register bank
`timescale 1ns/100ps
module drmsr_regs_bench;
	import drmsr_pkg::*;
	localparam int DLY = 8;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic supply_por_in = 1'b0;
	logic analog_fail_in = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic frame_end, trig, ack, pin, clr, irq;
	logic [1:0] sid;
	logic [3:0] srst;
	int errors = 0;
	int num_checks = 0;
	always #25 mclk_in = ~mclk_in;
	drmsr_regs #(.RESET_DELAY_CYC(DLY)) drmsr_regs_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.supply_por_in(supply_por_in), .analog_fail_in(analog_fail_in), .trigger_input_in(trig),
		.frame_end_in(frame_end), .frame_subsys_in(sid), .wb_cyc_in(cyc), .wb_stb_in(cyc),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .status_toggle_pin_out(pin), .prepare_out(), .output_toggle_out(),
		.dac_clear_out(clr), .subsys_reset_out(srst), .irq_out(irq));
	drmsr_host_model #(.DELAY(DLY)) drmsr_host_model_i (.mclk_in(mclk_in),
		.frame_end_out(frame_end), .subsys_out(sid), .trigger_out(trig));
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk_in);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge mclk_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) chk("ack", 32'h0, 32'h1);
		q = rdat;
		cyc <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, q, exp);
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic t_supply();
		rd(IDX_SUPPLY_WATCH, 32'h0000CAFE, "supply powerup");
		rd(IDX_SOFT_RESET, {16'h0000, HW_VERSION}, "version");
		wr(IDX_SUPPLY_WATCH, 32'h00001234);
		rd(IDX_SUPPLY_WATCH, 32'h0000ABBA, "supply init");
		rd(IDX_SUPPLY_WATCH, 32'h0000BAAB, "supply alt");
		rd(IDX_SUPPLY_WATCH, 32'h0000ABBA, "supply back");
		@(posedge mclk_in);
		supply_por_in <= 1'b1;
		@(posedge mclk_in);
		supply_por_in <= 1'b0;
		rd(IDX_SUPPLY_WATCH, 32'h0000CAFE, "supply collapse");
		rd(4'h0, 32'h0, "unmapped");
		$display("test supply done");
	endtask : t_supply
	task automatic t_swr();
		wr(IDX_TOGGLE_DIV, 32'h3);
		wr(IDX_SUPPLY_WATCH, 32'h0);
		wr(IDX_SOFT_RESET, 32'h1234);
		drmsr_host_model_i.frame(2'h0);
		@(negedge mclk_in);
		chk("no reset", 32'(srst), 32'h0);
		wr(IDX_SOFT_RESET, 32'hA5A5);
		drmsr_host_model_i.frame(2'h2);
		@(negedge mclk_in);
		chk("other subsys", 32'(srst), 32'h0);
		wr(IDX_SOFT_RESET, 32'hA5A5);
		drmsr_host_model_i.frame(2'h0);
		@(negedge mclk_in);
		chk("own subsys", 32'(srst), 32'h1);
		drmsr_host_model_i.settle();
		@(negedge mclk_in);
		chk("reset ended", 32'(srst), 32'h0);
		rd(IDX_SUPPLY_WATCH, 32'h0000CAFE, "supply default");
		rd(IDX_TOGGLE_DIV, 32'h0, "divider default");
		$display("test soft reset done");
	endtask : t_swr
	task automatic t_div();
		logic p;
		for (int d = 0; d < 3; d++) begin
			wr(IDX_TOGGLE_DIV, 32'(d));
			@(negedge mclk_in);
			p = pin;
			drmsr_host_model_i.pulses((1 << d) - 1);
			@(negedge mclk_in);
			chk("pin held", {31'h0, pin}, {31'h0, p});
			drmsr_host_model_i.pulses(1);
			@(negedge mclk_in);
			chk("pin toggled", {31'h0, pin}, {31'h0, ~p});
		end
		wr(IDX_TOGGLE_DIV, 32'hFFFF);
		rd(IDX_TOGGLE_DIV, 32'h7, "divider field");
		@(negedge mclk_in);
		p = pin;
		drmsr_host_model_i.pulses(63);
		@(negedge mclk_in);
		chk("div7 held", {31'h0, pin}, {31'h0, p});
		drmsr_host_model_i.pulses(1);
		@(negedge mclk_in);
		chk("div7 toggled", {31'h0, pin}, {31'h0, ~p});
		$display("test divider done");
	endtask : t_div
	task automatic t_irq();
		logic a;
		wr(IDX_IRQ_STATUS, 32'hF);
		analog_fail_in <= 1'b1;
		repeat (2) @(negedge mclk_in);
		chk("clear state", {31'h0, clr}, 32'h1);
		@(posedge mclk_in);
		analog_fail_in <= 1'b0;
		rd(IDX_SUPPLY_WATCH, 32'h0000CAFE, "supply untouched");
		rd(IDX_IRQ_STATUS, 32'h4, "analog event");
		wr(IDX_IRQ_MASK, 32'h0);
		@(negedge mclk_in);
		a = irq;
		wr(IDX_IRQ_MASK, 32'hF);
		@(negedge mclk_in);
		chk("irq masked", {31'h0, a}, 32'h0);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(IDX_IRQ_STATUS, 32'h4);
		rd(IDX_IRQ_STATUS, 32'h0, "status cleared");
		@(negedge mclk_in);
		chk("irq low", {31'h0, irq}, 32'h0);
		$display("test interrupt done");
	endtask : t_irq
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (5) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		t_supply();
		t_swr();
		t_div();
		t_irq();
		close_out();
	end
	initial begin
		#2_000_000;
		errors++;
		close_out();
	end
endmodule : drmsr_regs_bench

// ---- hdl/drmsr_pkg.sv ----
// Package with register map, reset values and timing for the reset/monitor status registers
package drmsr_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int WORD_W = 16;
	// Register indices (byte address is four times the index)
	localparam logic [ADDR_W-1:0] IDX_SUPPLY_WATCH = 4'h6;
	localparam logic [ADDR_W-1:0] IDX_SOFT_RESET = 4'h7;
	localparam logic [ADDR_W-1:0] IDX_TOGGLE_DIV = 4'h9;
	localparam logic [ADDR_W-1:0] IDX_CONTROL = 4'hA;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 4'hB;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 4'hC;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 4'hD;
	// Values of the words
	localparam logic [WORD_W-1:0] SOFT_RESET_MAGIC = 16'hA5A5;
	localparam logic [WORD_W-1:0] SUPPLY_POWERUP = 16'hCAFE;
	localparam logic [WORD_W-1:0] SUPPLY_INIT_A = 16'hABBA;
	localparam logic [WORD_W-1:0] SUPPLY_INIT_B = 16'hBAAB;
	localparam logic [WORD_W-1:0] HW_VERSION = 16'h0001; // Arbitrary value
	localparam logic [WORD_W-1:0] TOGGLE_DIV_RESET = 16'h0000;
	// Toggle divider field
	localparam int DIV_W = 3;
	localparam logic [DIV_W-1:0] DIV_MAX = 3'h6;
	localparam int TRIG_CNT_W = 6;
	// Control bits
	localparam int CTRL_SUBSYS_LSB = 0;
	localparam int CTRL_SUBSYS_W = 2;
	localparam int NUM_SUBSYS = 4;
	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_SOFT_RESET = 0;
	localparam int IRQ_SUPPLY_FAIL = 1;
	localparam int IRQ_ANALOG_FAIL = 2;
	localparam int IRQ_TRIG_TOGGLE = 3;
	// Status bits
	localparam int STAT_CLEAR = 0;
	localparam int STAT_RESETTING = 1;
	localparam int STAT_TOGGLE_PIN = 2;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int SOFT_RESET_US = 50;
	localparam int SOFT_RESET_CYC = SOFT_RESET_US * (CLK_HZ / 1_000_000);
	localparam int RST_CNT_W = 11;
endpackage : drmsr_pkg

// ---- hdl/drmsr_regs.sv ----
// Reset, supply monitor and status toggle register bank with Wishbone slave
//
// Behaviour
// R01 - Magic write resets subsystem at frame end
// R02 - Soft reset returns all state to defaults (control, interrupt status and mask registers keep their values)
// R03 - Soft reset word reads hardware version
// R04 - Supply word holds power-up marker
// R05 - Any supply word write loads init marker
// R06 - Supply collapse reset restores power-up marker
// R07 - Host treats power-up marker as failure
// R08 - Each supply word read swaps patterns
// R09 - Only digital supply tracked; analog fail clears
// R10 - Divider is 3-bit field, values 0-6
// R11 - Pin toggles every two-power-divider trigger pulses
// R12 - Host changes divider only after reset
// R13 - Prepare on trigger rise, toggle on fall
// R14 - Soft reset reaches addressed subsystem only
// R15 - Host waits reset delay after soft reset
// R16 - Non-magic write starts no reset
// R17 - Trigger counter cleared by reset; 7 unsupported
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
module drmsr_regs
	import drmsr_pkg::*;
#(
	parameter int RESET_DELAY_CYC = drmsr_pkg::SOFT_RESET_CYC
) (
	input wire logic mclk_in, // System clock, 20 MHz
	input wire logic reset_n_in, // Async reset, active low
	// Supply monitors and host frame
	input wire logic supply_por_in, // Digital supply collapse reset pulse
	input wire logic analog_fail_in, // Analog positive supply failure level
	input wire logic trigger_input_in, // Trigger input level
	input wire logic frame_end_in, // Chip-select rising edge pulse
	input wire logic [drmsr_pkg::CTRL_SUBSYS_W-1:0] frame_subsys_in, // Subsystem of the frame
	// Register bus
	input wire logic wb_cyc_in, // Wishbone cycle
	input wire logic wb_stb_in, // Wishbone strobe
	input wire logic wb_we_in, // Wishbone write enable
	input wire logic [drmsr_pkg::ADDR_W-1:0] wb_adr_in, // Wishbone word address
	input wire logic [3:0] wb_sel_in, // Wishbone byte selects
	input wire logic [drmsr_pkg::DATA_W-1:0] wb_dat_in, // Wishbone write data
	output logic [drmsr_pkg::DATA_W-1:0] wb_dat_out, // Wishbone read data
	output logic wb_ack_out, // Wishbone acknowledge
	// Device side outputs
	output logic status_toggle_pin_out, // Status toggle pin
	output logic prepare_out, // Pulse: DAC registers prepared
	output logic output_toggle_out, // Pulse: DAC outputs toggle
	output logic dac_clear_out, // All DAC channels in clear state
	output logic [drmsr_pkg::NUM_SUBSYS-1:0] subsys_reset_out, // Per-subsystem reset
	output logic irq_out // Interrupt, active high
);
	logic [WORD_W-1:0] supply_q;
	logic [WORD_W-1:0] div_q;
	logic [CTRL_SUBSYS_W-1:0] own_id_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic pend_reset_q;
	logic resetting_q;
	logic [RST_CNT_W-1:0] rst_cnt_q;
	logic trig_q;
	logic trig_prev_q;
	logic armed_q;
	logic toggled;
	logic toggle_lvl;
	logic acc;
	logic wr;
	logic rd;
	logic soft_clr;
	logic fire;
	logic trig_rise;
	logic trig_fall;
	logic [IRQ_W-1:0] irq_set;
	logic [DATA_W-1:0] rd_d;
	logic wr_lo;

	// Decoded register selects and strobes
	logic sel_supply;
	logic sel_soft;
	logic sel_div;
	logic sel_ctrl;
	logic sel_irq_stat;
	logic sel_irq_mask;
	logic sel_status;
	logic wr_supply;
	logic rd_supply;
	logic wr_soft;
	logic wr_div;
	logic wr_ctrl;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic [IRQ_W-1:0] irq_pend;

	assign acc = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr = acc && wb_we_in;
	assign rd = acc && !wb_we_in;
	assign wr_lo = wr && (wb_sel_in[1:0] == 2'b11);
	// Magic word armed by a write; reset fires at the frame end for our subsystem
	assign fire = frame_end_in && pend_reset_q && (frame_subsys_in == own_id_q); // [R01] [R14]
	assign soft_clr = fire;
	assign trig_rise = trig_q && !trig_prev_q;
	assign trig_fall = !trig_q && trig_prev_q;

	// Write and read strobes per register
	assign wr_supply = wr && sel_supply;
	assign rd_supply = rd && sel_supply;
	assign wr_soft = wr_lo && sel_soft;
	assign wr_div = wr && sel_div && wb_sel_in[0];
	assign wr_ctrl = wr && sel_ctrl && wb_sel_in[0];
	assign wr_irq_stat = wr && sel_irq_stat && wb_sel_in[0];
	assign wr_irq_mask = wr && sel_irq_mask && wb_sel_in[0];
	assign irq_pend = (irq_stat_q | irq_set) & irq_mask_q;

	// Address decode, one select per mapped word
	always_comb begin
		sel_supply = 1'b0;
		sel_soft = 1'b0;
		sel_div = 1'b0;
		sel_ctrl = 1'b0;
		sel_irq_stat = 1'b0;
		sel_irq_mask = 1'b0;
		sel_status = 1'b0;
		if (wb_adr_in == IDX_SUPPLY_WATCH) begin
			sel_supply = 1'b1;
		end else if (wb_adr_in == IDX_SOFT_RESET) begin
			sel_soft = 1'b1;
		end else if (wb_adr_in == IDX_TOGGLE_DIV) begin
			sel_div = 1'b1;
		end else if (wb_adr_in == IDX_CONTROL) begin
			sel_ctrl = 1'b1;
		end else if (wb_adr_in == IDX_IRQ_STATUS) begin
			sel_irq_stat = 1'b1;
		end else if (wb_adr_in == IDX_IRQ_MASK) begin
			sel_irq_mask = 1'b1;
		end else if (wb_adr_in == IDX_STATUS) begin
			sel_status = 1'b1;
		end
	end

	// Wishbone ack, one cycle after the request is seen
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= acc;
		end
	end

	// Pending magic word; cleared by frame end either way
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend_reset_q <= 1'b0;
		end else if (wr_soft) begin
			pend_reset_q <= (wb_dat_in[WORD_W-1:0] == SOFT_RESET_MAGIC); // [R01] [R16]
		end else if (frame_end_in) begin
			pend_reset_q <= 1'b0;
		end
	end

	// Reset pulse held for the reset delay
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			resetting_q <= 1'b0;
			rst_cnt_q <= '0;
		end else if (fire) begin
			resetting_q <= 1'b1;
			rst_cnt_q <= RST_CNT_W'(RESET_DELAY_CYC - 1);
		end else if (resetting_q) begin
			if (rst_cnt_q == '0) begin
				resetting_q <= 1'b0;
			end else begin
				rst_cnt_q <= rst_cnt_q - 1'b1;
			end
		end
	end

	// One reset flop per subsystem; only the own subsystem is driven
	generate
		for (genvar i = 0; i < NUM_SUBSYS; i++) begin : g_sub
			always_ff @(posedge mclk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					subsys_reset_out[i] <= 1'b0;
				end else begin
					subsys_reset_out[i] <= (fire || resetting_q) && (own_id_q == i); // [R14]
				end
			end
		end
	endgenerate

	// Supply watch word
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			supply_q <= SUPPLY_POWERUP; // [R04]
		end else if (supply_por_in) begin
			supply_q <= SUPPLY_POWERUP; // [R06] [R09]
		end else if (soft_clr) begin
			supply_q <= SUPPLY_POWERUP; // [R02]
		end else if (wr_supply) begin
			supply_q <= SUPPLY_INIT_A; // [R05]
		end else if (rd_supply) begin
			if (supply_q == SUPPLY_INIT_A) begin
				supply_q <= SUPPLY_INIT_B; // [R08]
			end else if (supply_q == SUPPLY_INIT_B) begin
				supply_q <= SUPPLY_INIT_A; // [R08]
			end
		end
	end

	// Divider and control
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q <= TOGGLE_DIV_RESET;
		end else if (soft_clr) begin
			div_q <= TOGGLE_DIV_RESET; // [R02]
		end else if (wr_div) begin
			div_q[DIV_W-1:0] <= wb_dat_in[DIV_W-1:0]; // [R10]
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			own_id_q <= '0;
		end else if (wr_ctrl) begin
			own_id_q <= wb_dat_in[CTRL_SUBSYS_LSB +: CTRL_SUBSYS_W];
		end
	end

	// Trigger edge handling
	// A soft reset reloads both flops from the pin, so no false edge follows it
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trig_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else if (soft_clr) begin
			trig_q <= trigger_input_in; // [R02]
			trig_prev_q <= trigger_input_in;
		end else begin
			trig_q <= trigger_input_in;
			trig_prev_q <= trig_q;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			armed_q <= 1'b0;
			prepare_out <= 1'b0;
			output_toggle_out <= 1'b0;
		end else if (soft_clr) begin
			armed_q <= 1'b0;
			prepare_out <= 1'b0;
			output_toggle_out <= 1'b0;
		end else begin
			prepare_out <= trig_rise; // [R13]
			output_toggle_out <= trig_fall && armed_q; // [R13]
			if (trig_rise) begin
				armed_q <= 1'b1;
			end else if (trig_fall) begin
				armed_q <= 1'b0;
			end
		end
	end

	drmsr_toggle_div u_div (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.sync_clr_in(soft_clr),
		.trig_rise_in(trig_rise),
		.div_in(div_q[DIV_W-1:0]),
		.toggle_out(toggle_lvl),
		.toggled_out(toggled)
	);

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_toggle_pin_out <= 1'b0;
			dac_clear_out <= 1'b0;
		end else begin
			status_toggle_pin_out <= toggle_lvl; // [R11]
			dac_clear_out <= analog_fail_in; // [R09]
		end
	end

	// Interrupts: set wins over write-one-to-clear
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_SOFT_RESET] = fire;
		irq_set[IRQ_SUPPLY_FAIL] = supply_por_in;
		irq_set[IRQ_ANALOG_FAIL] = analog_fail_in && !dac_clear_out;
		irq_set[IRQ_TRIG_TOGGLE] = toggled;
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_stat_q <= '0;
		end else if (wr_irq_stat) begin
			irq_stat_q <= (irq_stat_q & ~wb_dat_in[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_mask_q <= '0;
		end else if (wr_irq_mask) begin
			irq_mask_q <= wb_dat_in[IRQ_W-1:0];
		end
	end

	// Level interrupt, high while an unmasked status bit is set
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |irq_pend;
		end
	end

	// Read mux
	always_comb begin
		rd_d = '0;
		if (sel_supply) begin
			rd_d[WORD_W-1:0] = supply_q;
		end else if (sel_soft) begin
			rd_d[WORD_W-1:0] = HW_VERSION; // [R03]
		end else if (sel_div) begin
			rd_d[WORD_W-1:0] = div_q;
		end else if (sel_ctrl) begin
			rd_d[CTRL_SUBSYS_LSB +: CTRL_SUBSYS_W] = own_id_q;
		end else if (sel_irq_stat) begin
			rd_d[IRQ_W-1:0] = irq_stat_q;
		end else if (sel_irq_mask) begin
			rd_d[IRQ_W-1:0] = irq_mask_q;
		end else if (sel_status) begin
			rd_d[STAT_CLEAR] = dac_clear_out;
			rd_d[STAT_RESETTING] = resetting_q;
			rd_d[STAT_TOGGLE_PIN] = status_toggle_pin_out;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_dat_out <= '0;
		end else if (rd) begin
			wb_dat_out <= rd_d;
		end
	end
endmodule : drmsr_regs

// ---- hdl/drmsr_toggle_div.sv ----
// Trigger pulse divider driving the status toggle pin
`timescale 1ns/100ps
module drmsr_toggle_div
	import drmsr_pkg::*;
(
	input wire logic mclk_in, // System clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic sync_clr_in, // Soft reset clear
	input wire logic trig_rise_in, // Trigger rising edge pulse
	input wire logic [drmsr_pkg::DIV_W-1:0] div_in, // Divider setting
	output logic toggle_out, // Status toggle level
	output logic toggled_out // Pulse when level changes
);
	logic [TRIG_CNT_W-1:0] cnt_q;
	logic [TRIG_CNT_W-1:0] limit;
	logic hit;

	// Setting 7 is unsupported and held at the top valid value
	always_comb begin
		if (div_in > DIV_MAX) begin // [R17]
			limit = TRIG_CNT_W'((1 << DIV_MAX) - 1);
		end else begin
			limit = TRIG_CNT_W'((1 << div_in) - 1);
		end
	end

	assign hit = trig_rise_in && (cnt_q >= limit);

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= '0;
		end else if (sync_clr_in) begin
			cnt_q <= '0; // [R17]
		end else if (hit) begin
			cnt_q <= '0;
		end else if (trig_rise_in) begin
			cnt_q <= cnt_q + 1'b1; // [R11]
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			toggle_out <= 1'b0;
			toggled_out <= 1'b0;
		end else if (sync_clr_in) begin
			toggle_out <= 1'b0;
			toggled_out <= 1'b0;
		end else begin
			toggle_out <= toggle_out ^ hit; // [R11]
			toggled_out <= hit;
		end
	end
endmodule : drmsr_toggle_div
